//--- logic/cdfs_pkg.sv
// constants, field layouts and mode encodings for the codec link frame block
package cdfs_pkg;
    // register byte offsets on the avalon slave, one 32-bit word each, a 16-byte group of four words for each buffer
    localparam logic [7:0] CDFS_ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] CDFS_ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] CDFS_ADDR_STATUS   = 8'h08;
    localparam logic [7:0] CDFS_ADDR_TX_SLOTS = 8'h0C;
    localparam logic [7:0] CDFS_ADDR_RX_SLOTS = 8'h10;
    localparam logic [7:0] CDFS_ADDR_TX_BUF   = 8'h20;
    localparam logic [7:0] CDFS_ADDR_RX_BUF   = 8'h30;

    // converter_ctrl_one fields
    localparam int CDFS_C1_ON_BIT      = 15;
    localparam int CDFS_C1_EDGE_BIT    = 9;
    localparam int CDFS_C1_FS_DIR_BIT  = 8;
    localparam int CDFS_C1_IDLE_BIT    = 6;
    localparam int CDFS_C1_MODE_LSB    = 0;
    // converter_ctrl_two fields
    localparam int CDFS_C2_BUFFER_LENGTH_SEL_LSB    = 10;
    localparam int CDFS_C2_FLEN_LSB    = 5;
    localparam int CDFS_C2_WS_LSB      = 0;
    // converter_status fields
    localparam int CDFS_ST_SLOT_LSB    = 8;
    localparam int CDFS_ST_ROV_BIT     = 3;
    localparam int CDFS_ST_RFUL_BIT    = 2;
    localparam int CDFS_ST_TUNF_BIT    = 1;
    localparam int CDFS_ST_TMPTY_BIT   = 0;

    // values after reset
    localparam logic [15:0] CDFS_CTRL_ONE_RST = 16'h0000;
    localparam logic [15:0] CDFS_CTRL_TWO_RST = 16'h0000;
    localparam logic [15:0] CDFS_SLOTS_RST    = 16'h0000;
    localparam logic [15:0] CDFS_BUF_RST      = 16'h0000;

    // frame geometry: lengths in serial clock cycles, plus slot indices, masks and buffer words
    localparam logic [8:0]  CDFS_FS_HIGH_BITS     = 9'd16;
    localparam logic [8:0]  CDFS_CODEC_FRAME_BITS = 9'd256;
    localparam logic [4:0]  CDFS_WORD_BITS        = 5'd16;
    localparam logic [4:0]  CDFS_AC16_SLOT_BITS   = 5'd20;
    localparam logic [3:0]  CDFS_AC16_LAST_SLOT   = 4'hC;
    localparam logic [3:0]  CDFS_AC20_LAST_SLOT   = 4'hF;
    localparam logic [3:0]  CDFS_AC20_WORD_SEL    = 4'hF;
    localparam logic [15:0] CDFS_AC16_SLOT_MASK   = 16'h1FFF;
    localparam int          CDFS_BUF_WORDS        = 4;

    // frame sync mode selections
    typedef enum logic [1:0] {
        CDFS_MULTI,
        CDFS_I2S,
        CDFS_AC16,
        CDFS_AC20
    } cdfs_mode_e;
endpackage

//--- logic/cdfs_link_if.sv
// synchronised link events passed from the pin synchroniser to the core
`timescale 1ns/1ps
interface cdfs_link_if;
    logic sclk_rise;
    logic sclk_fall;
    logic fsync;
    logic sdi;
    modport src (output sclk_rise, output sclk_fall, output fsync, output sdi);
    modport dst (input sclk_rise, input sclk_fall, input fsync, input sdi);
endinterface

//--- logic/cdfs_pin_sync.sv
// two-stage synchronisers and serial clock edge finder for the link pins
`timescale 1ns/1ps
module cdfs_pin_sync
    import cdfs_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_arst_n,
    input  wire logic i_sclk,
    input  wire logic i_fsync,
    input  wire logic i_sdi,
    cdfs_link_if.src  lnk
);
    logic [2:0] meta;
    logic [2:0] sync;
    logic       sclk_d;

    // first stage feeds only the second; edges come from stage two and its copy
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta   <= 3'h0;
            sync   <= 3'h0;
            sclk_d <= 1'b0;
        end else begin
            meta   <= {i_sdi, i_fsync, i_sclk};
            sync   <= meta;
            sclk_d <= sync[0];
        end
    end

    // edge pulses last one master clock cycle
    assign lnk.sclk_rise = sync[0] & ~sclk_d;
    assign lnk.sclk_fall = ~sync[0] & sclk_d;
    assign lnk.fsync     = sync[1];
    assign lnk.sdi       = sync[2];
endmodule

//--- logic/cdfs_fsync_gen.sv
// frame sync generator: frame position counter and sync level on drive edges
`timescale 1ns/1ps
module cdfs_fsync_gen
    import cdfs_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    input  wire logic       i_en,
    input  wire logic       i_tick,
    input  wire logic       i_codec,
    input  wire logic [8:0] i_frame_bits,
    output logic            o_fsync,
    output logic            o_frame_start
);
    logic [8:0] pos;
    wire  [8:0] frame_bits = i_codec ? CDFS_CODEC_FRAME_BITS : i_frame_bits;
    wire  [8:0] last_pos   = frame_bits - 9'd1;
    wire  [8:0] next_pos   = (pos >= last_pos) ? 9'd0 : pos + 9'd1;
    wire        next_fsync = i_codec ? (next_pos < CDFS_FS_HIGH_BITS) : (next_pos == 9'd0);

    // position advances once per serial clock; idle parks on the last bit
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pos           <= 9'd0;
            o_fsync       <= 1'b0;
            o_frame_start <= 1'b0;
        end else if (!i_en) begin
            pos           <= last_pos;
            o_fsync       <= 1'b0;
            o_frame_start <= 1'b0;
        end else begin
            o_frame_start <= i_tick && next_pos == 9'd0;
            if (i_tick) begin
                pos     <= next_pos;
                o_fsync <= next_fsync;
            end
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    a_fsync_duty_codec: assert property (
        $past(i_en) && i_en && $past(i_codec) && i_codec && $past(i_tick) |-> o_fsync == (pos < CDFS_FS_HIGH_BITS))
        else $error("frame sync level does not match sixteen high cycles");
    a_frame_wrap_256: assert property (
        i_en && i_codec && i_tick && pos == 9'd255 |=> pos == 9'd0 && o_frame_start)
        else $error("codec frame did not wrap after 256 bits");
endmodule

//--- logic/cdfs_codec_link.sv
// codec link serial converter with avalon registers, slot engine and dma request
`timescale 1ns/1ps
module cdfs_codec_link
    import cdfs_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_sclk,
    input  wire logic        i_fsync,
    output logic             o_fsync,
    output logic             o_fsync_oe,
    input  wire logic        i_sdi,
    output logic             o_sdo,
    output logic             o_sdo_oe,
    output logic             o_dma_req
);
    // buffer register hit for a 16-byte group of four words
    function automatic logic buf_hit(input logic [7:0] addr, input logic [7:0] base);
        buf_hit = addr[7:4] == base[7:4];
    endfunction

    cdfs_link_if lnk ();

    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [15:0] tx_slots;
    logic [15:0] rx_slots;
    logic [15:0] tx_buf [CDFS_BUF_WORDS];
    logic [15:0] rx_buf [CDFS_BUF_WORDS];
    logic [15:0] rx_hold [CDFS_BUF_WORDS];
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [3:0]  slot;
    logic [4:0]  bitc;
    logic [1:0]  idx;
    logic        active;
    logic        pending;
    logic        fs_prev;
    logic        drive_q;
    logic        ack;
    logic        rov;
    logic        rful;
    logic        tunf;
    logic        tmpty;
    logic        gen_fsync;
    logic        gen_start;

    cdfs_pin_sync u_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_sclk   (i_sclk),
        .i_fsync  (i_fsync),
        .i_sdi    (i_sdi),
        .lnk      (lnk.src)
    );

    // configuration decode
    wire             on       = ctrl_one[CDFS_C1_ON_BIT];
    wire             fs_dir   = ctrl_one[CDFS_C1_FS_DIR_BIT];
    wire             edge_sel = ctrl_one[CDFS_C1_EDGE_BIT];
    wire             idle_sel = ctrl_one[CDFS_C1_IDLE_BIT];
    wire cdfs_mode_e mode     = cdfs_mode_e'(ctrl_one[CDFS_C1_MODE_LSB +: 2]);
    wire             ac16     = mode == CDFS_AC16;
    wire             ac20     = mode == CDFS_AC20;
    wire             codec    = ac16 | ac20;
    wire [1:0]       buffer_length_sel     = ctrl_two[CDFS_C2_BUFFER_LENGTH_SEL_LSB +: 2];
    wire [3:0]       flen     = ctrl_two[CDFS_C2_FLEN_LSB +: 4];
    wire [3:0]       ws_raw   = ctrl_two[CDFS_C2_WS_LSB +: 4];

    // word size and frame length: fixed by the protocol in codec modes
    wire [3:0]  ws_eff    = ac20 ? CDFS_AC20_WORD_SEL : ws_raw;
    wire [4:0]  dw        = ac16 ? CDFS_WORD_BITS : {1'b0, ws_eff} + 5'd1;
    wire [3:0]  last_slot = ac16 ? CDFS_AC16_LAST_SLOT : (ac20 ? CDFS_AC20_LAST_SLOT : flen);
    wire [4:0]  slot_len  = (ac16 && slot != 4'h0) ? CDFS_AC16_SLOT_BITS : dw;
    wire [8:0]  mc_bits   = ({5'h0, flen} + 9'd1) * ({5'h0, ws_raw} + 9'd1);
    wire [15:0] slot_mask = ac16 ? CDFS_AC16_SLOT_MASK : 16'hFFFF;
    wire [15:0] tx_en     = tx_slots & slot_mask;
    wire [15:0] rx_en     = rx_slots & slot_mask;

    // serial clock edges: data driven on one edge, sampled on the other
    wire drive_edge  = on & (edge_sel ? lnk.sclk_fall : lnk.sclk_rise);
    wire sample_edge = on & (edge_sel ? lnk.sclk_rise : lnk.sclk_fall);

    cdfs_fsync_gen u_fsg (
        .i_mclk        (i_mclk),
        .i_arst_n      (i_arst_n),
        .i_en          (on & ~fs_dir),
        .i_tick        (drive_edge),
        .i_codec       (codec),
        .i_frame_bits  (mc_bits),
        .o_fsync       (gen_fsync),
        .o_frame_start (gen_start)
    );

    // frame start: own generator as master, codec's frame sync edge as slave
    wire ext_start   = drive_edge & fs_dir & lnk.fsync & ~fs_prev;
    wire frame_start = fs_dir ? ext_start : gen_start;

    // slot progress and buffer block accounting
    wire       slot_tx   = active & tx_en[slot];
    wire       slot_rx   = active & rx_en[slot];
    wire       slot_end  = drive_edge & active & ~pending & (bitc == slot_len - 5'd1);
    wire       commit    = slot_end & (slot_tx | slot_rx);
    wire       blk_full  = commit & (idx == buffer_length_sel);
    wire [1:0] next_idx  = blk_full ? 2'd0 : (commit ? idx + 2'd1 : idx);
    wire       tx_on     = slot_tx & (bitc < dw);
    wire [4:0] ld_shift  = CDFS_WORD_BITS - dw;

    // frame and slot counters stepped on drive edges
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slot    <= 4'h0;
            bitc    <= 5'd0;
            active  <= 1'b0;
            pending <= 1'b0;
            fs_prev <= 1'b0;
            idx     <= 2'd0;
            tx_sh   <= CDFS_BUF_RST;
        end else if (!on) begin
            slot    <= 4'h0;
            bitc    <= 5'd0;
            active  <= 1'b0;
            pending <= 1'b0;
            idx     <= 2'd0;
        end else begin
            if (drive_edge) begin
                fs_prev <= lnk.fsync;
            end
            if (frame_start) begin
                pending <= 1'b1;
            end else if (drive_edge && pending) begin
                pending <= 1'b0;
                active  <= 1'b1;
                slot    <= 4'h0;
                bitc    <= 5'd0;
                tx_sh   <= tx_buf[idx] << ld_shift;
            end else if (slot_end) begin
                idx  <= next_idx;
                bitc <= 5'd0;
                if (slot == last_slot) begin
                    active <= 1'b0;
                end else begin
                    slot  <= slot + 4'h1;
                    tx_sh <= tx_buf[next_idx] << ld_shift;
                end
            end else if (drive_edge && active) begin
                bitc  <= bitc + 5'd1;
                tx_sh <= {tx_sh[14:0], 1'b0};
            end
        end
    end

    // serial output updated one master cycle after each drive edge
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            drive_q  <= 1'b0;
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            drive_q <= drive_edge;
            if (!on) begin
                o_sdo    <= 1'b0;
                o_sdo_oe <= 1'b0;
            end else if (drive_q) begin
                o_sdo    <= tx_on & tx_sh[15]; // zero pad past dw bits
                o_sdo_oe <= tx_on | ~idle_sel;
            end
        end
    end

    // receive shift: only the first dw bits of a slot are kept
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_sh <= CDFS_BUF_RST;
        end else if (slot_end || (drive_edge && pending)) begin
            rx_sh <= CDFS_BUF_RST;
        end else if (sample_edge && slot_rx && bitc < dw) begin
            rx_sh <= {rx_sh[14:0], lnk.sdi};
        end
    end

    // per-word receive holding and block hand-over to the visible buffers
    genvar gi;
    generate
        for (gi = 0; gi < CDFS_BUF_WORDS; gi++) begin : g_rx
            always_ff @(posedge i_mclk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    rx_hold[gi] <= CDFS_BUF_RST;
                    rx_buf[gi]  <= CDFS_BUF_RST;
                end else begin
                    if (commit && slot_rx && idx == 2'(gi)) begin
                        rx_hold[gi] <= rx_sh;
                    end
                    if (blk_full) begin
                        rx_buf[gi] <= (idx == 2'(gi) && slot_rx) ? rx_sh : rx_hold[gi];
                    end
                end
            end
        end
    endgenerate

    // avalon slave: one wait cycle, answer at the second edge
    wire        acc     = i_avs_read | i_avs_write;
    wire        wr_take = i_avs_write & ack;
    wire        rd_take = i_avs_read & ack;
    wire [1:0]  bidx    = i_avs_address[3:2];
    wire        hit_tx  = buf_hit(i_avs_address, CDFS_ADDR_TX_BUF);
    wire        hit_rx  = buf_hit(i_avs_address, CDFS_ADDR_RX_BUF);
    wire [15:0] stat    = {4'h0, slot, 4'h0, rov, rful, tunf, tmpty};
    wire [15:0] rd_mux  = (i_avs_address == CDFS_ADDR_CTRL_ONE) ? ctrl_one :
                          (i_avs_address == CDFS_ADDR_CTRL_TWO) ? ctrl_two :
                          (i_avs_address == CDFS_ADDR_STATUS)   ? stat :
                          (i_avs_address == CDFS_ADDR_TX_SLOTS) ? tx_slots :
                          (i_avs_address == CDFS_ADDR_RX_SLOTS) ? rx_slots :
                          hit_tx ? tx_buf[bidx] :
                          hit_rx ? rx_buf[bidx] : 16'h0000;
    assign o_avs_waitrequest = acc & ~ack;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack            <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= acc & ~ack;
            if (i_avs_read && !ack) begin
                o_avs_readdata <= {16'h0000, rd_mux};
            end
        end
    end

    // control registers written at the accepting edge
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_one <= CDFS_CTRL_ONE_RST;
            ctrl_two <= CDFS_CTRL_TWO_RST;
            tx_slots <= CDFS_SLOTS_RST;
            rx_slots <= CDFS_SLOTS_RST;
        end else if (wr_take) begin
            if (i_avs_address == CDFS_ADDR_CTRL_ONE) ctrl_one <= i_avs_writedata[15:0];
            if (i_avs_address == CDFS_ADDR_CTRL_TWO) ctrl_two <= i_avs_writedata[15:0];
            if (i_avs_address == CDFS_ADDR_TX_SLOTS) tx_slots <= i_avs_writedata[15:0];
            if (i_avs_address == CDFS_ADDR_RX_SLOTS) rx_slots <= i_avs_writedata[15:0];
        end
    end

    // transmit buffer words (word-wide writes only)
    generate
        for (gi = 0; gi < CDFS_BUF_WORDS; gi++) begin : g_tx
            always_ff @(posedge i_mclk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    tx_buf[gi] <= CDFS_BUF_RST;
                end else if (wr_take && hit_tx && bidx == 2'(gi)) begin
                    tx_buf[gi] <= i_avs_writedata[15:0];
                end
            end
        end
    endgenerate

    // status flags: hardware set wins over software clear
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rov       <= 1'b0;
            rful      <= 1'b0;
            tunf      <= 1'b0;
            tmpty     <= 1'b1;
            o_dma_req <= 1'b0;
        end else begin
            o_dma_req <= blk_full;
            if (blk_full) begin
                rful <= 1'b1;
            end else if (rd_take && hit_rx) begin
                rful <= 1'b0;
            end
            if (blk_full && rful) begin
                rov <= 1'b1;
            end else if (wr_take && i_avs_address == CDFS_ADDR_STATUS && i_avs_writedata[CDFS_ST_ROV_BIT]) begin
                rov <= 1'b0;
            end
            if (commit && slot_tx && tmpty) begin
                tunf <= 1'b1;
            end else if (wr_take && i_avs_address == CDFS_ADDR_STATUS && i_avs_writedata[CDFS_ST_TUNF_BIT]) begin
                tunf <= 1'b0;
            end
            if (blk_full) begin
                tmpty <= 1'b1;
            end else if (wr_take && hit_tx) begin
                tmpty <= 1'b0;
            end
        end
    end

    // frame sync pin: driven while the link is on and the direction bit is clear
    assign o_fsync    = gen_fsync & ~fs_dir;
    assign o_fsync_oe = on & ~fs_dir;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    sequence s_block_done;
        blk_full ##1 o_dma_req;
    endsequence

    a_fsync_out_dir: assert property (on && !fs_dir |-> o_fsync_oe && o_fsync == gen_fsync)
        else $error("frame sync not driven out with direction bit clear");
    a_sample_falling: assert property (sample_edge && !edge_sel |-> lnk.sclk_fall)
        else $error("data sampled on wrong serial clock edge");
    a_ac16_slot_mask: assert property (ac16 && active |-> slot <= CDFS_AC16_LAST_SLOT)
        else $error("slot index beyond 12 in 16-bit link mode");
    a_ac16_zero_pad: assert property (on && ac16 && drive_q && bitc >= CDFS_WORD_BITS |=> !o_sdo)
        else $error("pad bits of a 20-bit slot are not zero");
    a_ac20_word_fix: assert property (ac20 |-> dw == CDFS_WORD_BITS && last_slot == CDFS_AC20_LAST_SLOT)
        else $error("word size or frame length field took effect in 20-bit mode");
    a_slot_restart: assert property (on && drive_edge && pending && !frame_start |=> slot == 4'h0 && active)
        else $error("slot index not cleared at frame start");
    a_block_dma_req: assert property (blk_full |-> s_block_done)
        else $error("dma request missing after transfer complete");
    a_buffer_length_sel_count: assert property (blk_full |=> idx == 2'd0 && rful)
        else $error("buffer block accounting wrong at transfer complete");
    a_slot_step: assert property (slot_end && slot != last_slot |=> slot == $past(slot) + 4'h1)
        else $error("slot index did not advance at slot boundary");
endmodule

//--- verif/cdfs_codec_model.sv
// codec partner: free running bit clock, serial data source and frame watcher
`timescale 1ns/1ps
module cdfs_codec_model (
    input  wire logic  i_fsync,
    input  wire logic  i_sdo,
    output logic       o_sclk,
    output logic       o_sdi,
    output logic       o_fsync,
    output logic [15:0] o_rx_word,
    output logic [8:0] o_hi_cnt,
    output logic [8:0] o_frame_cnt
);
    localparam logic [15:0] WORD = 16'h6C39;
    logic        fs_q = 1'b0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] rsh = 16'h0000;
    logic [8:0]  hi = 9'h000;
    logic [8:0]  len = 9'h000;
    logic [4:0]  nb = 5'h10;
    logic [7:0]  fc = 8'h00;
    initial begin
        o_sclk = 1'b0;
        o_sdi = 1'b0;
        o_fsync = 1'b0;
        o_rx_word = 16'h0000;
        o_hi_cnt = 9'h000;
        o_frame_cnt = 9'h000;
    end
    // the codec owns the bit clock and keeps it running
    always #24 o_sclk = ~o_sclk;
    // frame counts, data out msb first, slot 0 capture of the device data
    always @(posedge o_sclk) begin
        fs_q <= i_fsync;
        // own frame sync for slave use: 16 high out of every 256 clocks
        fc <= fc + 8'h01;
        o_fsync <= fc < 8'h10;
        len <= len + 9'h001;
        hi <= i_fsync ? hi + 9'h001 : hi;
        o_sdi <= sh[15];
        sh <= {sh[14:0], ~sh[15]};
        if (nb < 5'h10) begin
            rsh <= {rsh[14:0], i_sdo};
            nb <= nb + 5'h01;
        end
        if (nb == 5'h0F) o_rx_word <= {rsh[14:0], i_sdo};
        if (!i_fsync && fs_q) o_hi_cnt <= hi;
        if (i_fsync && !fs_q) begin
            o_frame_cnt <= len;
            len <= 9'h001;
            hi <= 9'h001;
            nb <= 5'h00;
            o_sdi <= WORD[15];
            sh <= {WORD[14:0], 1'b0};
        end
    end
endmodule

//--- verif/tb_cdfs_codec_link.sv
// bench for the codec link block: register access, frame timing, dma spacing
`timescale 1ns/1ps
module tb_cdfs_codec_link;
    import cdfs_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdv, q;
    logic        wrq, sclk, fs, fs_oe, sdi, sdo, dma, s, mfs, soe;
    logic [15:0] mrx;
    logic [8:0]  mhi, mlen;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          d;
    realtime     t0, t1, t2;
    // per row: mode, buffer length, slot enables, dma spacing in ns (0 none)
    // last row: slave use, the codec drives frame sync
    logic [1:0]  md [6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3};
    logic [1:0]  bl [6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h0, 2'h0};
    logic [15:0] en [6] = '{16'h0001, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hE000, 16'h0001};
    int          gap [6] = '{12288, 768, 1536, 3072, 0, 12288};
    logic        sl [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    wire         fs_pin = fs_oe ? fs : mfs;
    always #2.5 i_mclk = ~i_mclk;
    cdfs_codec_link uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdv), .o_avs_waitrequest(wrq),
        .i_sclk(sclk), .i_fsync(mfs), .o_fsync(fs), .o_fsync_oe(fs_oe), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe(soe), .o_dma_req(dma));
    cdfs_codec_model codec (.i_fsync(fs_pin), .i_sdo(sdo), .o_sclk(sclk), .o_sdi(sdi), .o_fsync(mfs),
        .o_rx_word(mrx), .o_hi_cnt(mhi), .o_frame_cnt(mlen));
    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= x;
        do begin
            @(posedge i_mclk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        q = rdv;
        if (n == 50) error_cnt++;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic wait_dma(output realtime t);
        int n;
        n = 0;
        s = 1'b0;
        while (!s && n < 3000) begin
            @(posedge i_mclk);
            n++;
            s = (dma === 1'b1);
        end
        t = $realtime;
    endtask
    // hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
        bus(1'b0, CDFS_ADDR_STATUS, 32'h0);
        check("status reset", 32'h1, q);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped read", 32'h0, q);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, CDFS_ADDR_CTRL_ONE, 32'h0);
            bus(1'b1, CDFS_ADDR_CTRL_TWO, 32'({bl[i], 10'h000}));
            bus(1'b1, CDFS_ADDR_TX_SLOTS, 32'(en[i]));
            bus(1'b1, CDFS_ADDR_RX_SLOTS, 32'(en[i]));
            bus(1'b1, CDFS_ADDR_TX_BUF, 32'hA5C3);
            bus(1'b1, CDFS_ADDR_CTRL_ONE, 32'h8000 | 32'(md[i]) | (32'(sl[i]) << 8));
            check("fsync oe", 32'(!sl[i]), 32'(fs_oe));
            wait_dma(t0);
            wait_dma(t1);
            wait_dma(t2);
            d = int'(t2 - t1);
            if (gap[i] == 0)
                check("dma none", 32'h0, 32'(s));
            else
                check("dma gap", gap[i], (d > gap[i] - 10 && d < gap[i] + 10) ? gap[i] : d);
            if (gap[i] == 0 || gap[i] == 12288) begin
                check("sync high", 32'd16, 32'(mhi));
                check("frame bits", 32'd256, 32'(mlen));
            end
            if (i == 0) begin
                check("tx slot word", 32'hA5C3, 32'(mrx));
                check("sdo oe", 32'h1, 32'(soe));
                bus(1'b0, CDFS_ADDR_RX_BUF, 32'h0);
                check("rx slot word", 32'h6C39, q);
            end
        end
        complete_run();
    end
endmodule
